// ### rtl/ovsavg_accum.sv
// Signed accumulator for one channel with shift-based division
`default_nettype none
module ovsavg_accum
  import ovsavg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic add,
  input wire logic signed [ovsavg_pkg::SAMPLE_W-1:0] sample,
  input wire logic [ovsavg_pkg::RATIO_W-1:0] shift,
  output logic signed [ovsavg_pkg::SAMPLE_W-1:0] average
);
  logic signed [ACC_W-1:0] accReg;
  logic signed [ACC_W-1:0] shifted;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accReg <= '0;
    end else if (ce) begin
      if (clear) begin
        accReg <= '0;
      end else if (add) begin
        // Sign extension keeps twos complement sums exact
        accReg <= accReg + ACC_W'(sample);
      end
    end
  end

  // Arithmetic shift divides by the ratio
  assign shifted = accReg >>> shift;
  assign average = shifted[SAMPLE_W-1:0];
endmodule : ovsavg_accum
`default_nettype wire

// ### rtl/ovsavg_pkg.sv
// Package: constants for the oversampling averager
`default_nettype none
package ovsavg_pkg;
  localparam int CHANNELS = 8;
  localparam int SAMPLE_W = 16;
  localparam int RATIO_W = 3;
  localparam int ACC_W = SAMPLE_W + 6;
  localparam logic [2:0] RATIO_NONE = 3'h0;
  localparam logic [2:0] RATIO_MAX = 3'h6;
  localparam logic [2:0] RATIO_BAD = 3'h7;
  // Register map over APB (byte addresses)
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] RESULT_BASE = 12'h010;
  localparam int CTRL_START_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam int STATUS_BAD_BIT = 2;
  localparam int STATUS_RANGE_BIT = 3;
  localparam int STATUS_REFINT_BIT = 4;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // Internal sample pacing: 5 us per conversion slot at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int SAMPLE_PERIOD_NS = 5000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS * CLK_MHZ / 1000;
  typedef enum logic [1:0] {IDLE, CONVERT, WAITNEXT, FINISH} ovsavg_state_t;
endpackage : ovsavg_pkg
`default_nettype wire

// ### rtl/ovsavg_top.sv
// Oversampling averaging filter with APB register access
`default_nettype none
module ovsavg_top
  import ovsavg_pkg::*;
#(
  parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic conv_start_group_a,
  input wire logic conv_start_group_b,
  input wire logic [ovsavg_pkg::RATIO_W-1:0] average_ratio_select,
  input wire logic range_select,
  input wire logic reference_source_select,
  input wire logic [ovsavg_pkg::CHANNELS*ovsavg_pkg::SAMPLE_W-1:0] sampleData,
  input wire logic sampleValid,
  output logic sampleStrobe,
  output logic front_end_gain_stage,
  output logic bandgapEnable,
  output logic refAmpEnable,
  output logic reference_pin_oe_n,
  output logic resultValid,
  output logic busy,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ovsavg_pkg::*;

  function automatic logic [6:0] ratio_count(input logic [2:0] code);
    ratio_count = 7'(1) << code;
  endfunction : ratio_count

  logic [1:0] syncA, syncB;
  logic [RATIO_W-1:0] ratioS1, ratioS2;
  logic [1:0] syncRange, syncRef;
  logic startPrev, swStartReg;
  logic startLevel, startEdge;
  ovsavg_state_t stateReg;
  logic [RATIO_W-1:0] shiftReg;
  logic [6:0] countReg;
  logic [15:0] waitReg;
  logic clearAcc, addAcc;
  logic doneReg;
  logic signed [SAMPLE_W-1:0] avg [CHANNELS];
  logic [SAMPLE_W-1:0] resultReg [CHANNELS];
  logic ratioBad;
  logic [2:0] resIdx;

  // Two-stage synchronisers for all pin inputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA <= '0;
      syncB <= '0;
      ratioS1 <= '0;
      ratioS2 <= '0;
      syncRange <= '0;
      syncRef <= '0;
    end else if (ce) begin
      syncA <= {syncA[0], conv_start_group_a};
      syncB <= {syncB[0], conv_start_group_b};
      ratioS1 <= average_ratio_select;
      ratioS2 <= ratioS1;
      syncRange <= {syncRange[0], range_select};
      syncRef <= {syncRef[0], reference_source_select};
    end
  end

  // Ratio pins are quasi-static: the host settles them before a start edge
  assign ratioBad = (ratioS2 == RATIO_BAD);

  // Both groups sample together, so the burst starts when both are high
  assign startLevel = syncA[1] & syncB[1];
  assign startEdge = (startLevel & ~startPrev) | swStartReg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      startPrev <= 1'b0;
    end else if (ce) begin
      startPrev <= startLevel;
    end
  end

  // A refused start must neither clear the sums nor raise busy
  assign clearAcc = (stateReg == IDLE) && startEdge && !ratioBad;
  assign addAcc = (stateReg == CONVERT) && sampleValid;

  // Burst sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg <= IDLE;
      shiftReg <= '0;
      countReg <= '0;
      waitReg <= '0;
      sampleStrobe <= 1'b0;
    end else if (ce) begin
      sampleStrobe <= 1'b0;
      unique case (stateReg)
        IDLE: begin
          // Invalid code 111 is refused rather than guessed at
          if (startEdge && !ratioBad) begin
            shiftReg <= ratioS2;
            countReg <= ratio_count(ratioS2);
            sampleStrobe <= 1'b1;
            stateReg <= CONVERT;
          end
        end
        CONVERT: begin
          if (sampleValid) begin
            countReg <= countReg - 7'd1;
            waitReg <= 16'(SAMPLE_CYC - 1);
            stateReg <= (countReg == 7'd1) ? FINISH : WAITNEXT;
          end
        end
        WAITNEXT: begin
          // Later samples need no host edge
          if (waitReg == 16'd0) begin
            sampleStrobe <= 1'b1;
            stateReg <= CONVERT;
          end else begin
            waitReg <= waitReg - 16'd1;
          end
        end
        FINISH: begin
          stateReg <= IDLE;
        end
      endcase
    end
  end

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    ovsavg_accum u_acc (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .clear(clearAcc),
      .add(addAcc),
      .sample(sampleData[ch*SAMPLE_W +: SAMPLE_W]),
      .shift(shiftReg),
      .average(avg[ch])
    );
  end

  // Results latch once per burst
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        resultReg[i] <= '0;
      end
      resultValid <= 1'b0;
    end else if (ce) begin
      resultValid <= 1'b0;
      if (stateReg == FINISH) begin
        for (int i = 0; i < CHANNELS; i++) begin
          resultReg[i] <= avg[i];
        end
        resultValid <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      front_end_gain_stage <= 1'b0;
      bandgapEnable <= 1'b0;
      refAmpEnable <= 1'b0;
      reference_pin_oe_n <= 1'b1;
    end else if (ce) begin
      busy <= (stateReg != IDLE) || clearAcc;
      front_end_gain_stage <= syncRange[1];
      bandgapEnable <= syncRef[1];
      reference_pin_oe_n <= ~syncRef[1];
      refAmpEnable <= 1'b1;
    end
  end

  // Sticky done flag: a new burst end wins over a clearing write
  logic doneClr;
  assign doneClr = psel && penable && pwrite && paddr == STATUS_ADDR
                   && pwdata[STATUS_DONE_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      doneReg <= 1'b0;
    end else if (ce) begin
      if (stateReg == FINISH) begin
        doneReg <= 1'b1;
      end else if (doneClr && pready) begin
        doneReg <= 1'b0;
      end
    end
  end

  // Result window offset to channel index
  assign resIdx = 3'((paddr - RESULT_BASE) >> 2);

  // APB slave: one wait cycle, answer in the access phase's second edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      swStartReg <= 1'b0;
    end else if (ce) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      swStartReg <= 1'b0;
      // A start write acts at the completing edge, like any other write
      if (psel && penable && pready && pwrite && paddr == CTRL_ADDR) begin
        swStartReg <= pwdata[CTRL_START_BIT];
      end
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= UNMAPPED_DATA;
        if (pwrite) begin
          if (paddr != CTRL_ADDR && paddr != STATUS_ADDR) begin
            pslverr <= 1'b1;
          end
        end else if (paddr == STATUS_ADDR) begin
          prdata[STATUS_BUSY_BIT] <= busy;
          prdata[STATUS_DONE_BIT] <= doneReg;
          prdata[STATUS_BAD_BIT] <= ratioBad;
          prdata[STATUS_RANGE_BIT] <= syncRange[1];
          prdata[STATUS_REFINT_BIT] <= syncRef[1];
        end else if (paddr >= RESULT_BASE && paddr < RESULT_BASE + 12'h020
                     && paddr[1:0] == 2'b00) begin
          prdata <= {{16{resultReg[resIdx][SAMPLE_W-1]}},
                     resultReg[resIdx]};
        end else if (paddr != CTRL_ADDR) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule : ovsavg_top
`default_nettype wire

// ### sim/oversampling_averager_tb.sv
// Bench: bursts at every ratio, refused code, unmapped access
`default_nettype none
module oversampling_averager_tb
  import ovsavg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic conv_start_group_a = 1'b0, conv_start_group_b = 1'b0;
  logic [2:0] average_ratio_select = 3'h0;
  logic range_select = 1'b0, reference_source_select = 1'b0;
  logic [127:0] sampleData;
  logic sampleValid, sampleStrobe, front_end_gain_stage, bandgapEnable;
  logic refAmpEnable, reference_pin_oe_n, resultValid, busy, pready;
  logic pslverr, err, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  int errors = 0, checks_done = 0, nval, acc[8];
  ovsavg_top #(.SAMPLE_CYC(4)) u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .conv_start_group_a(conv_start_group_a),
    .conv_start_group_b(conv_start_group_b),
    .average_ratio_select(average_ratio_select),
    .range_select(range_select),
    .reference_source_select(reference_source_select),
    .sampleData(sampleData),
    .sampleValid(sampleValid),
    .sampleStrobe(sampleStrobe),
    .front_end_gain_stage(front_end_gain_stage),
    .bandgapEnable(bandgapEnable),
    .refAmpEnable(refAmpEnable),
    .reference_pin_oe_n(reference_pin_oe_n),
    .resultValid(resultValid),
    .busy(busy),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );
  ovsavg_conv u_conv (
    .clk(clk),
    .sampleStrobe(sampleStrobe),
    .sampleData(sampleData),
    .sampleValid(sampleValid)
  );
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    if (sampleValid === 1'b1) begin
      nval++;
      for (int c = 0; c < 8; c++) acc[c] += $signed(sampleData[c*16 +: 16]);
    end
  end
  task automatic wrap_up;
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d = 32'h0000_0000);
    int n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr} <= {2'b10, w, a};
    pwdata <= w ? d : $urandom;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      errors++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic pulse;
    @(posedge clk);
    {conv_start_group_a, conv_start_group_b} <= 2'b11;
    repeat (4) @(posedge clk);
    {conv_start_group_a, conv_start_group_b} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask : pulse
  task automatic wait_result;
    int n;
    for (n = 0; n < 3000 && resultValid !== 1'b1; n++) @(posedge clk);
    if (n == 3000) begin
      errors++;
      wrap_up();
    end
    repeat (2) @(posedge clk);
  endtask : wait_result
  task automatic burst(input logic [2:0] r);
    average_ratio_select <= r;
    range_select <= 1'($urandom);
    reference_source_select <= 1'($urandom);
    nval = 0;
    acc = '{default: 0};
    pulse();
    // A second edge in mid-burst must not add samples
    if (r != 3'h0) pulse();
    wait_result();
    chk(busy, 1'b0);
    chk(nval, 32'h1 << r);
    for (int c = 0; c < 8; c++) begin
      apb(1'b0, RESULT_BASE + 12'(4 * c));
      chk(rd, 32'(acc[c] >>> r));
    end
    apb(1'b0, STATUS_ADDR);
    chk(rd[4:0], {reference_source_select, range_select, 3'h2});
    chk(front_end_gain_stage, range_select);
    chk(reference_pin_oe_n, !reference_source_select);
  endtask : burst
  initial begin
    void'($urandom(32'h618b_bab6));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Next start only after the result, keeping the host's rate limit
    for (int r = 0; r < 7; r++) burst(3'(r));
    // Sticky done clears on a write of one, then a software start
    apb(1'b1, STATUS_ADDR, 32'h0000_0002);
    apb(1'b0, STATUS_ADDR);
    chk(rd[1:0], 2'h0);
    nval = 0;
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    chk(err, 1'b0);
    wait_result();
    chk(nval, 32'h0000_0040);
    apb(1'b0, STATUS_ADDR);
    chk(rd[1:0], 2'h2);
    average_ratio_select <= RATIO_BAD;
    pulse();
    repeat (20) @(posedge clk);
    chk(busy, 1'b0);
    apb(1'b0, STATUS_ADDR);
    chk(rd[2], 1'b1);
    apb(1'b0, 12'h100);
    chk(err, 1'b1);
    chk(rd, UNMAPPED_DATA);
    wrap_up();
  end
endmodule : oversampling_averager_tb
bind ovsavg_top ovsavg_sva u_sva (
  .clk(clk),
  .rst_n(rst_n),
  .ce(ce),
  .average_ratio_select(average_ratio_select),
  .range_select(range_select),
  .reference_source_select(reference_source_select),
  .sampleStrobe(sampleStrobe),
  .front_end_gain_stage(front_end_gain_stage),
  .bandgapEnable(bandgapEnable),
  .refAmpEnable(refAmpEnable),
  .reference_pin_oe_n(reference_pin_oe_n),
  .resultValid(resultValid),
  .busy(busy)
);
`default_nettype wire

// ### sim/ovsavg_conv.sv
// Converter core model: answers each strobe with one set of samples
`default_nettype none
module ovsavg_conv (
  input wire logic clk,
  input wire logic sampleStrobe,
  output logic [127:0] sampleData,
  output logic sampleValid
);
  timeunit 1ns;
  timeprecision 1ns;
  int waitCnt = -1;
  initial begin
    sampleValid = 1'b0;
    sampleData = '0;
  end
  // Fresh data every cycle, so a late read never finds a held value
  always @(posedge clk) begin
    sampleData <= {$urandom, $urandom, $urandom, $urandom};
    sampleValid <= (waitCnt == 0);
    if (sampleStrobe === 1'b1) waitCnt <= $urandom_range(6, 0);
    else if (waitCnt >= 0) waitCnt <= waitCnt - 1;
  end
endmodule : ovsavg_conv
`default_nettype wire

// ### sim/ovsavg_sva.sv
// Checker for pin, burst and reference behaviour of the averager
`default_nettype none
module ovsavg_sva
  import ovsavg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [RATIO_W-1:0] average_ratio_select,
  input wire logic range_select,
  input wire logic reference_source_select,
  input wire logic sampleStrobe,
  input wire logic front_end_gain_stage,
  input wire logic bandgapEnable,
  input wire logic refAmpEnable,
  input wire logic reference_pin_oe_n,
  input wire logic resultValid,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] strobeCnt;
  // Cleared at each result so a stray start would show as extra strobes
  always_ff @(posedge clk) begin
    if (!rst_n || resultValid) strobeCnt <= 8'h00;
    else if (sampleStrobe) strobeCnt <= strobeCnt + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Pins pass two sync stages and an output flop: three cycles of lag
  a_gain_range: assert property (
    $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) &&
    $past(ce) && $past(ce, 2) && $past(ce, 3)
    |-> front_end_gain_stage == $past(range_select, 3))
    else $error("gain wrong");
  a_bandgap_ref: assert property (
    $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) &&
    $past(ce) && $past(ce, 2) && $past(ce, 3)
    |-> bandgapEnable == $past(reference_source_select, 3))
    else $error("bandgap");
  a_pin_dir: assert property (
    reference_pin_oe_n == !bandgapEnable) else $error("pin direction");
  a_amp_on: assert property (
    $past(rst_n) && $past(ce) |-> refAmpEnable) else $error("amp off");
  a_burst_count: assert property (
    resultValid |-> strobeCnt == (8'h01 << average_ratio_select))
    else $error("sample count wrong");
  a_bad_code: assert property (
    $rose(busy) |-> $past(average_ratio_select, 3) != RATIO_BAD)
    else $error("invalid code started");
  a_result_pulse: assert property (
    resultValid |=> !resultValid) else $error("result not a pulse");
  a_strobe_busy: assert property (
    sampleStrobe |-> ##[0:1] busy) else $error("strobe while idle");
  c_max_ratio: cover property (resultValid && average_ratio_select == 3'h6);
  c_start: cover property ($rose(busy));
  c_end: cover property ($fell(busy));
endmodule : ovsavg_sva
`default_nettype wire
